// file: design/brhu_top.sv
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Byte-reverse halfword unit with a classic Wishbone register slave.
module brhu_top
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [brhu_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import brhu_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Functions.

  // Merges a bus write into a stored word under the byte enables.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Evaluates a condition code against the flags (N Z C V, high to low).
  function automatic logic cond_holds(input logic [3:0] cond,
                                      input logic [3:0] f);
    logic res;
    res = 1'b1;
    case (cond[3:1])
      3'h0: res = f[2];
      3'h1: res = f[1];
      3'h2: res = f[3];
      3'h3: res = f[0];
      3'h4: res = f[1] & ~f[2];
      3'h5: res = (f[3] == f[0]);
      3'h6: res = (f[3] == f[0]) & ~f[2];
      default: res = 1'b1;
    endcase
    // Odd codes invert, except the never code 4'hf.
    if (cond[0] && (cond[3:1] != 3'h7))
    begin
      res = ~res;
    end
    return res;
  endfunction : cond_holds

  ////////////////////////////////////////////////////////////////////////
  // Storage.

  // Control: form, timing bit, condition pass for mixed forms, policy.
  logic [7:0] ctrl_reg;
  // Instruction latched at start.
  logic [31:0] instr_reg;
  // Condition flags; hardware only reads them.
  logic [3:0] flags_reg;
  // Last computed result.
  logic [31:0] result_reg;
  // Outcome bits of the last instruction.
  logic done_reg;
  logic wrote_reg;
  logic unpred_reg;
  logic undef_reg;
  logic nop_reg;
  logic sbo_reg;
  logic cfail_reg;
  logic [3:0] dest_reg;
  // Pending write-back, staged between the two execution cycles.
  logic commit_en_reg;
  // Sequencer.
  brhu_state_type state_reg;
  brhu_state_type state_next;
  // Bus answer.
  logic ack_reg;
  logic [31:0] rdata_reg;
  // The general register file this unit reads and writes.
  logic [31:0] gpr_mem [16];

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire bus_wr = bus_req && wb_we_i;
  wire sel_ctrl = (wb_adr_i == OFS_CTRL);
  wire sel_instr = (wb_adr_i == OFS_INSTR);
  wire sel_flags = (wb_adr_i == OFS_FLAGS);
  wire sel_result = (wb_adr_i == OFS_RESULT);
  wire sel_status = (wb_adr_i == OFS_STATUS);
  wire sel_gpr = (wb_adr_i[7:6] == GPR_WINDOW);
  wire [3:0] gpr_idx = wb_adr_i[5:2];
  wire busy = (state_reg != ST_IDLE);
  // A start is ignored while an instruction is still in flight.
  wire start = bus_wr && sel_instr && !busy;
  wire [1:0] ctrl_form = ctrl_reg[CTRL_FORM_LSB +: 2];
  wire ctrl_tib = ctrl_reg[CTRL_TIB_BIT];
  wire ctrl_cpass = ctrl_reg[CTRL_CPASS_BIT];
  wire [1:0] ctrl_pol = ctrl_reg[CTRL_POL_LSB +: 2];

  // Status word as software sees it.
  wire [31:0] status_word = {20'h00000, dest_reg, cfail_reg, sbo_reg,
                             nop_reg, undef_reg, unpred_reg, wrote_reg,
                             done_reg, busy};

  // Read multiplexer; unmapped offsets read as zero.
  wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_reg} :
                       sel_instr ? instr_reg :
                       sel_flags ? {28'h0000000, flags_reg} :
                       sel_result ? result_reg :
                       sel_status ? status_word :
                       sel_gpr ? gpr_mem[gpr_idx] : WORD_RST;

  ////////////////////////////////////////////////////////////////////////
  // Decode and datapath.

  logic dec_hit;
  logic dec_signed;
  logic [3:0] dec_rd;
  logic [3:0] dec_rm;
  logic [3:0] dec_rn;
  logic dec_has_cond;
  logic dec_pc_used;
  logic dec_mismatch;
  logic dec_sbo_bad;
  logic [31:0] swap_result;

  brhu_decode u_decode
  (
    .instr_i(instr_reg),
    .form_i(ctrl_form),
    .hit_o(dec_hit),
    .signed_o(dec_signed),
    .rd_o(dec_rd),
    .rm_o(dec_rm),
    .rn_o(dec_rn),
    .has_cond_o(dec_has_cond),
    .pc_used_o(dec_pc_used),
    .mismatch_o(dec_mismatch),
    .sbo_bad_o(dec_sbo_bad)
  );

  // Condition: fixed form checks its own field, mixed forms take the
  // pass bit supplied by the surrounding conditional-block logic.
  wire cond_ok = dec_has_cond ? cond_holds(instr_reg[31:28], flags_reg)
                              : ctrl_cpass;
  // Source index after the mismatch policy is applied.
  wire [3:0] src_idx = (dec_mismatch && (ctrl_pol == POL_DUP)) ? dec_rn
                                                                : dec_rm;
  wire [31:0] src_word = gpr_mem[src_idx];

  brhu_swap u_swap
  (
    .src_i(src_word),
    .signed_i(dec_signed),
    .result_o(swap_result)
  );

  // Outcome classes for the instruction in EXEC.
  wire is_undef = !dec_hit ||
                  (dec_mismatch && (ctrl_pol == POL_UNDEF));
  wire is_pc_bad = dec_hit && dec_pc_used;
  wire is_mm_nop = dec_mismatch && (ctrl_pol == POL_NOP);
  // Write-back happens on a recognised, passing instruction unless undefined, using register 15 or a no-op mismatch.
  wire do_write = dec_hit && cond_ok && !is_undef && !is_pc_bad &&
                  !is_mm_nop;
  // Without the timing bit, an instruction with nothing to write may
  // finish a cycle early; with it, every instruction takes the same
  // path so latency cannot leak data or flags.
  wire early_out = !ctrl_tib && !do_write;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state.

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        // A write to the instruction register starts execution.
        if (start)
        begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC:
      begin
        // The sequence cannot be cut short by anything outside; with the timing
        // bit set, the exception window never depends on operands or flags.
        state_next = early_out ? ST_IDLE : ST_COMMIT;
      end
      ST_COMMIT:
      begin
        // Write-back slot, always a single cycle.
        state_next = ST_IDLE;
      end
      default:
      begin
        // Recover from an illegal code.
        state_next = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer register.

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone answer: one wait state, ack for one cycle.

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= WORD_RST;
    end
    else
    begin
      ack_reg <= bus_req;
      rdata_reg <= (bus_req && !wb_we_i) ? rd_mux : WORD_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software-written registers.

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= CTRL_RST;
      instr_reg <= WORD_RST;
      flags_reg <= FLAGS_RST;
    end
    else
    begin
      // Control changes are held off while busy to keep decode stable.
      if (bus_wr && sel_ctrl && !busy && wb_sel_i[0])
      begin
        ctrl_reg <= wb_dat_i[7:0];
      end
      if (start)
      begin
        instr_reg <= merge_bytes(instr_reg, wb_dat_i, wb_sel_i);
      end
      // Flags are software state only; execution never writes them.
      if (bus_wr && sel_flags && wb_sel_i[0])
      begin
        flags_reg <= wb_dat_i[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Execution outcome capture.

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      result_reg <= WORD_RST;
      wrote_reg <= 1'b0;
      unpred_reg <= 1'b0;
      undef_reg <= 1'b0;
      nop_reg <= 1'b0;
      sbo_reg <= 1'b0;
      cfail_reg <= 1'b0;
      dest_reg <= 4'h0;
      commit_en_reg <= 1'b0;
    end
    else if (state_reg == ST_EXEC)
    begin
      result_reg <= swap_result;
      wrote_reg <= do_write;
      unpred_reg <= is_pc_bad || dec_mismatch;
      undef_reg <= is_undef;
      nop_reg <= !do_write;
      sbo_reg <= dec_sbo_bad;
      cfail_reg <= !cond_ok;
      dest_reg <= dec_rd;
      commit_en_reg <= do_write;
    end
    else if (state_reg == ST_COMMIT)
    begin
      commit_en_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Done flag: set by completion, cleared by writing one to its bit.

  wire done_set = (state_reg == ST_EXEC) && (state_next == ST_IDLE) ||
                  (state_reg == ST_COMMIT);
  wire done_clr = bus_wr && sel_status && wb_sel_i[0] &&
                  wb_dat_i[ST_DONE_BIT];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_reg <= 1'b0;
    end
    else if (done_set)
    begin
      // Completion wins over a clear in the same cycle.
      done_reg <= 1'b1;
    end
    else if (done_clr)
    begin
      done_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file: write-back has priority over a bus write.

  always_ff @(posedge clk_i)
  begin
    if ((state_reg == ST_COMMIT) && commit_en_reg)
    begin
      // Only the destination changes; nothing else is touched.
      gpr_mem[dest_reg] <= result_reg;
    end
    else if (bus_wr && sel_gpr)
    begin
      gpr_mem[gpr_idx] <= merge_bytes(gpr_mem[gpr_idx], wb_dat_i,
                                      wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, straight from flip-flops.

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule : brhu_top

// file: pkg/brhu_pkg.sv
// Summary of operation
// - Halfword swap exchanges bytes within each half.
// - Signed swap swaps low half, sign-extends.
// - Signed: bits 31:8 extend byte 7:0, low gets 15:8.
// - Fixed form: cond not ones, opcode and low nibble.
// - Compact form has 3-bit fields; wide otherwise.
// - Register 15 in fixed/compact form is unpredictable.
// - Wide form: field mismatch or register 15 unpredictable.
// - Mismatch: undefined, no-op, or either field used.
// - Stack pointer is an ordinary operand in wide form.
// - Signed wide form with register 15 is unpredictable.
// - With timing bit set, latency ignores data and flags.
// - Exception response ignores data and flags too.
// - Signed swap ignores the source's upper half.
package brhu_pkg;

  // Bus and register map.
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [1:0] GPR_WINDOW = 2'h1;

  // Control register fields and reset value.
  localparam int unsigned CTRL_FORM_LSB = 0;
  localparam int unsigned CTRL_TIB_BIT = 2;
  localparam int unsigned CTRL_CPASS_BIT = 3;
  localparam int unsigned CTRL_POL_LSB = 4;
  localparam logic [7:0] CTRL_RST = 8'h08;

  // Status register fields.
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;
  localparam int unsigned ST_WROTE_BIT = 2;
  localparam int unsigned ST_UNPRED_BIT = 3;
  localparam int unsigned ST_UNDEF_BIT = 4;
  localparam int unsigned ST_NOP_BIT = 5;
  localparam int unsigned ST_SBO_BIT = 6;
  localparam int unsigned ST_CFAIL_BIT = 7;
  localparam int unsigned ST_DEST_LSB = 8;

  // Other reset values.
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // Encoding forms and mismatch policies.
  typedef enum logic [1:0] {
    FORM_FIXED32 = 2'h0,
    FORM_COMPACT16 = 2'h1,
    FORM_WIDE32 = 2'h2
  } brhu_form_type;
  localparam logic [1:0] POL_UNDEF = 2'h0;
  localparam logic [1:0] POL_NOP = 2'h1;
  localparam logic [1:0] POL_DUP = 2'h2;
  localparam logic [1:0] POL_SRC = 2'h3;

  // Opcode patterns.
  localparam logic [3:0] COND_NEVER = 4'hf;
  localparam logic [3:0] COND_ALWAYS = 4'he;
  localparam logic [7:0] FX_SWAP_OP = 8'h6b;
  localparam logic [7:0] FX_SIGN_OP = 8'h6f;
  localparam logic [3:0] FX_LOW_OP = 4'hb;
  localparam logic [3:0] ALL_ONES4 = 4'hf;
  localparam logic [9:0] CP_SWAP_OP = 10'h2e9;
  localparam logic [9:0] CP_SIGN_OP = 10'h2eb;
  localparam logic [11:0] WD_HI_OP = 12'hfa9;
  localparam logic [3:0] WD_SWAP_OP = 4'h9;
  localparam logic [3:0] WD_SIGN_OP = 4'hb;
  localparam logic [3:0] REG_PC = 4'hf;

  // Execution sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_COMMIT = 3'h4
  } brhu_state_type;

endpackage : brhu_pkg

// file: design/brhu_decode.sv
`timescale 1ns/1ps
// Pure decoder: classifies the instruction word for the selected form.
module brhu_decode
(
  // Instruction and form.
  input wire logic [31:0] instr_i,
  input wire logic [1:0] form_i,
  // Decode results.
  output logic hit_o,
  output logic signed_o,
  output logic [3:0] rd_o,
  output logic [3:0] rm_o,
  output logic [3:0] rn_o,
  output logic has_cond_o,
  output logic pc_used_o,
  output logic mismatch_o,
  output logic sbo_bad_o
);
  import brhu_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Recognition per form.
  wire fx_swap = (instr_i[31:28] != COND_NEVER) &&
                 (instr_i[27:20] == FX_SWAP_OP) &&
                 (instr_i[7:4] == FX_LOW_OP);
  wire fx_sign = (instr_i[31:28] != COND_NEVER) &&
                 (instr_i[27:20] == FX_SIGN_OP) &&
                 (instr_i[7:4] == FX_LOW_OP);
  wire cp_swap = (instr_i[15:6] == CP_SWAP_OP);
  wire cp_sign = (instr_i[15:6] == CP_SIGN_OP);
  wire wd_base = (instr_i[31:20] == WD_HI_OP) &&
                 (instr_i[15:12] == ALL_ONES4);
  wire wd_swap = wd_base && (instr_i[7:4] == WD_SWAP_OP);
  wire wd_sign = wd_base && (instr_i[7:4] == WD_SIGN_OP);
  wire is_fx = (form_i == FORM_FIXED32);
  wire is_cp = (form_i == FORM_COMPACT16);
  wire is_wd = (form_i == FORM_WIDE32);

  // Field extraction; compact fields only reach the low eight registers.
  assign hit_o = is_fx ? (fx_swap | fx_sign) :
                 is_cp ? (cp_swap | cp_sign) :
                 is_wd ? (wd_swap | wd_sign) : 1'b0;
  assign signed_o = is_fx ? fx_sign : is_cp ? cp_sign : wd_sign;
  assign rd_o = is_fx ? instr_i[15:12] :
                is_cp ? {1'b0, instr_i[2:0]} : instr_i[11:8];
  assign rm_o = is_cp ? {1'b0, instr_i[5:3]} : instr_i[3:0];
  assign rn_o = is_wd ? instr_i[19:16] : rm_o;
  assign has_cond_o = is_fx;
  // Only register 15 is special; 13 passes as an ordinary operand.
  assign pc_used_o = (rd_o == REG_PC) || (rm_o == REG_PC);
  assign mismatch_o = is_wd && (rn_o != rm_o);
  assign sbo_bad_o = is_fx && ((instr_i[19:16] != ALL_ONES4) ||
                               (instr_i[11:8] != ALL_ONES4));

endmodule : brhu_decode

// file: design/brhu_swap.sv
`timescale 1ns/1ps
// Byte-swap datapath, fully combinational and data-independent in time.
module brhu_swap
(
  // Operand and operation.
  input wire logic [31:0] src_i,
  input wire logic signed_i,
  // Result.
  output logic [31:0] result_o
);
  import brhu_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Both results are always formed; the select is a plain mux so no path
  // depends on the operand value.
  wire [31:0] half_swap = {src_i[23:16], src_i[31:24],
                           src_i[7:0], src_i[15:8]};
  // Upper half of the source never enters the signed result.
  wire [31:0] sign_swap = {{16{src_i[7]}}, src_i[7:0],
                           src_i[15:8]};

  assign result_o = signed_i ? sign_swap : half_swap;

endmodule : brhu_swap

// file: verif/brhu_monitor.sv
`timescale 1ns/1ps
// Checks bus timing and the side effects that show at the bus pins.
module brhu_monitor
  import brhu_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus signals at the unit.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [brhu_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////
  logic [3:0] flags_reg; // Flags as software last wrote them.
  logic [31:0] pc_reg; // Register 15 as software last wrote it.
  logic pc_ok_reg; // Register 15 shadow holds a known word.
  logic [2:0] since_reg; // Edges since an instruction write, saturating.
  wire wr_ack = wb_ack_o && wb_we_i;
  wire rd_ack = wb_ack_o && !wb_we_i;
  wire hole = (wb_adr_i > OFS_STATUS) && (wb_adr_i < 8'h40);
  // Shadows move only on bus writes, so the hardware must never differ.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_reg <= FLAGS_RST;
    else if (wr_ack && wb_adr_i == OFS_FLAGS && wb_sel_i[0])
      flags_reg <= wb_dat_i[3:0];
  end
  // The register file is not reset, so the shadow starts unknown.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pc_ok_reg <= 1'b0;
    else if (wr_ack && wb_adr_i == 8'h7c)
    begin
      pc_ok_reg <= (wb_sel_i == 4'hf);
      pc_reg <= wb_dat_i;
    end
  end
  // Counts edges after a start; saturates so it never wraps.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      since_reg <= 3'h7;
    else if (wr_ack && wb_adr_i == OFS_INSTR)
      since_reg <= 3'h0;
    else if (since_reg != 3'h7)
      since_reg <= since_reg + 3'h1;
  end
  //////////////////////////////////////////////////////////////////////
  a_ack_follows:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered after one cycle");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_ack_caused:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without a request");
  a_dat_quiet:
    assert property (!rd_ack |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside a read answer");
  a_hole_zero:
    assert property (rd_ack && hole |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_flags_kept:
    assert property (rd_ack && wb_adr_i == OFS_FLAGS |->
      wb_dat_o[3:0] == flags_reg)
    else $error("flags changed by hardware");
  a_pc_untouched:
    assert property (rd_ack && wb_adr_i == 8'h7c && pc_ok_reg |->
      wb_dat_o == pc_reg)
    else $error("register 15 written by hardware");
  a_busy_bounded:
    assert property (rd_ack && wb_adr_i == OFS_STATUS && since_reg > 3'h3
      |-> !wb_dat_o[ST_BUSY_BIT])
    else $error("busy held too long");
endmodule : brhu_monitor

bind brhu_top brhu_monitor i_monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);

// file: verif/brhu_host_model.sv
`timescale 1ns/1ps
// Bus master standing in for the decode stage, one word per request.
module brhu_host_model
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Request from the bench.
  input wire logic go_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  // Bus.
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o = 1'b0,
  output logic we_o = 1'b0,
  output logic [7:0] adr_o = 8'h00,
  output logic [31:0] dat_o = 32'h0,
  // Answer to the bench.
  output logic done_o = 1'b0,
  output logic [31:0] rdata_o = 32'h0
);
  // Holds the request until ack is sampled, then releases it and inverts
  // the address and data lines, so a stale value can never pass for a fresh one.
  always @(posedge clk_i)
  begin
    done_o <= cyc_o && ack_i && !rst_i;
    if (rst_i)
      cyc_o <= 1'b0;
    else if (cyc_o && ack_i)
    begin
      cyc_o <= 1'b0;
      dat_o <= ~dat_o;
      adr_o <= ~adr_o;
      rdata_o <= rdat_i;
    end
    else if (!cyc_o && go_i)
    begin
      cyc_o <= 1'b1;
      we_o <= we_i;
      adr_o <= adr_i;
      dat_o <= dat_i;
    end
  end
endmodule : brhu_host_model

// file: verif/testbench.sv
`timescale 1ns/1ps
// Self-checking bench: drivers queue notes, a watcher compares answers.
module testbench;
  import brhu_pkg::*;
  typedef struct {
    logic chk;
    string name;
    logic [31:0] mask;
    logic [31:0] exp;
  } brhu_note_type;
  localparam logic [31:0] M32 = 32'hffffffff;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic t_we = 1'b0;
  logic [7:0] t_adr = 8'h00;
  logic [31:0] t_dat = 32'h0;
  logic cyc, we, ack, m_done;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, m_rdata, v, b, p, e;
  logic [31:0] seed = 32'hc23d;
  logic [3:0] rd, rm;
  brhu_note_type notes[$];
  brhu_note_type cur;
  int err_count = 0;
  int tests_run = 0;
  int f, k;
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  brhu_host_model i_host (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .we_i(t_we), .adr_i(t_adr), .dat_i(t_dat), .ack_i(ack), .rdat_i(rdat),
    .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(wdat), .done_o(m_done),
    .rdata_o(m_rdata));
  // Byte lanes stay all on: every access here is a whole word.
  brhu_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Expected swap, worked out independently of the datapath.
  function automatic logic [31:0] sw16(input logic [31:0] x,
    input logic sg);
    if (sg)
      return {{16{x[7]}}, x[7:0], x[15:8]};
    return {x[23:16], x[31:24], x[7:0], x[15:8]};
  endfunction : sw16
  function automatic logic [31:0] mk(input logic [1:0] fm, input logic sg,
    input logic [3:0] cn, input logic [3:0] d, input logic [3:0] m,
    input logic [3:0] n);
    if (fm == 2'h0)
      return {cn, sg ? FX_SIGN_OP : FX_SWAP_OP, ALL_ONES4, d, ALL_ONES4,
        FX_LOW_OP, m};
    if (fm == 2'h1)
      return {16'h0, sg ? CP_SIGN_OP : CP_SWAP_OP, m[2:0], d[2:0]};
    return {WD_HI_OP, n, ALL_ONES4, d, sg ? WD_SIGN_OP : WD_SWAP_OP, m};
  endfunction : mk
  function automatic logic [31:0] ctl(input logic [1:0] fm, input logic t,
    input logic cp, input logic [1:0] pol);
    return {26'h0, pol, cp, t, fm};
  endfunction : ctl
  function automatic logic [7:0] gpr(input logic [3:0] i);
    return 8'h40 + {2'b00, i, 2'b00};
  endfunction : gpr
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] ex,
    input logic [31:0] seen);
    tests_run++;
    if (seen !== ex)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", name, ex, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  // One bus request; the answer time is left to the unit.
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    t_we <= w;
    t_adr <= a;
    t_dat <= d;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (m_done !== 1'b1 && n < 20);
    if (m_done !== 1'b1)
      check("bus answer", 32'h1, 32'h0);
  endtask : bus
  task automatic rd_chk(input string name, input logic [7:0] a,
    input logic [31:0] m, input logic [31:0] ex);
    notes.push_back('{1'b1, name, m, ex});
    bus(1'b0, a, 32'h0);
  endtask : rd_chk
  // Starts an instruction and polls until the unit is idle again.
  task automatic run(input logic [31:0] ins);
    int n;
    n = 0;
    bus(1'b1, OFS_INSTR, ins);
    do
    begin
      notes.push_back('{1'b0, "", 32'h0, 32'h0});
      bus(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    while (m_rdata[ST_BUSY_BIT] !== 1'b0 && n < 8);
    check("busy", 32'h0, {31'h0, m_rdata[ST_BUSY_BIT]});
  endtask : run
  // Watcher: each read answer is matched with the oldest note.
  always @(posedge clk_i)
  begin
    if (m_done === 1'b1 && t_we === 1'b0)
    begin
      cur = notes.pop_front();
      if (cur.chk)
        check(cur.name, cur.exp & cur.mask, m_rdata & cur.mask);
    end
  end
  // Cuts a hang short; the whole run needs well under a thousand cycles.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("ctrl", OFS_CTRL, 32'hff, {24'h0, CTRL_RST});
    rd_chk("status", OFS_STATUS, M32, WORD_RST);
    rd_chk("result", OFS_RESULT, M32, WORD_RST);
    rd_chk("hole", 8'h20, M32, 32'h0);
    v = rnd();
    bus(1'b1, OFS_FLAGS, v);
    rd_chk("flags", OFS_FLAGS, 32'hf, v);
    bus(1'b1, OFS_FLAGS, 32'h0);
    $display("reset test ended");
    for (f = 0; f < 3; f++)
      for (k = 0; k < 4; k++)
      begin
        v = rnd();
        rm = {1'b0, v[26:24]};
        rd = (f == 2 && k == 3) ? 4'hd : {1'b0, v[30:28]};
        bus(1'b1, gpr(rm), v);
        bus(1'b1, OFS_CTRL, ctl(f[1:0], k[0], 1'b1, POL_UNDEF));
        run(mk(f[1:0], k[1], COND_ALWAYS, rd, rm, rm));
        rd_chk("dest", gpr(rd), M32, sw16(v, k[1]));
        rd_chk("result", OFS_RESULT, M32, sw16(v, k[1]));
        rd_chk("status", OFS_STATUS, 32'hfbf, {20'h0, rd, 8'h06});
      end
    $display("swap test ended");
    for (f = 0; f < 2; f++)
    begin
      p = rnd();
      bus(1'b1, gpr(4'h6), p);
      bus(1'b1, OFS_CTRL, ctl(f[1:0], !f[0], 1'b0, POL_UNDEF));
      run(mk(f[1:0], 1'b0, 4'h0, 4'h6, 4'h1, 4'h1));
      rd_chk("kept", gpr(4'h6), M32, p);
      rd_chk("cfail", OFS_STATUS, 32'h80, 32'h80);
    end
    $display("condition test ended");
    for (k = 0; k < 2; k++)
    begin
      p = rnd();
      rd = k ? 4'h3 : 4'hf;
      rm = k ? 4'hf : 4'h2;
      bus(1'b1, gpr(rd), p);
      bus(1'b1, OFS_CTRL, ctl(k ? 2'h2 : 2'h0, 1'b1, 1'b1, POL_UNDEF));
      run(mk(k ? 2'h2 : 2'h0, k[0], COND_ALWAYS, rd, rm, rm));
      rd_chk("kept", gpr(rd), M32, p);
      rd_chk("unpred", OFS_STATUS, 32'h0c, 32'h08);
    end
    $display("register 15 test ended");
    v = rnd();
    b = rnd();
    bus(1'b1, gpr(4'h4), v);
    bus(1'b1, gpr(4'h5), b);
    for (k = 0; k < 4; k++)
    begin
      p = rnd();
      bus(1'b1, gpr(4'h6), p);
      bus(1'b1, OFS_CTRL, ctl(2'h2, 1'b1, 1'b1, k[1:0]));
      run(mk(2'h2, 1'b0, COND_ALWAYS, 4'h6, 4'h4, 4'h5));
      e = (k == 2) ? sw16(b, 1'b0) : (k == 3) ? sw16(v, 1'b0) : p;
      rd_chk("policy", gpr(4'h6), M32, e);
      rd_chk("unpred", OFS_STATUS, 32'h18, k ? 32'h08 : 32'h18);
    end
    $display("mismatch test ended");
    bus(1'b1, OFS_CTRL, ctl(2'h0, 1'b1, 1'b1, POL_UNDEF));
    run(mk(2'h0, 1'b0, COND_ALWAYS, 4'h2, 4'h4, 4'h4) & 32'hfff0ffff);
    rd_chk("sbo dest", gpr(4'h2), M32, sw16(v, 1'b0));
    rd_chk("sbo flag", OFS_STATUS, 32'h40, 32'h40);
    run(mk(2'h0, 1'b0, COND_NEVER, 4'h2, 4'h4, 4'h4));
    rd_chk("undef", OFS_STATUS, 32'h14, 32'h10);
    $display("encoding test ended");
    give_verdict();
  end
endmodule : testbench
